// [core/dac_cal_regs.svh]
/*
 * Register offsets, field positions, reset values and fixed codes of the channel calibration path.
 * Assumes inclusion from the design module, the checker and the bench; definitions, no logic.
 */
`ifndef DAC_CAL_REGS_SVH
`define DAC_CAL_REGS_SVH

`define CFG_OFFSET          12'h000
`define STATUS_OFFSET       12'h004
`define OFFSET_A_OFFSET     12'h008
`define OFFSET_B_OFFSET     12'h00C
`define INPUT_BASE          12'h040
`define DATA_BASE           12'h060
`define GAIN_BASE           12'h080
`define ZERO_BASE           12'h0A0
`define LATCH_BASE          12'h0C0

`define CFG_CE_BIT          0
`define CFG_GAIN_BIT        1
`define CFG_SINGLE_BIT      2
`define CFG_LOAD_BIT        3

`define GAIN_RESET          12'h800
`define ZERO_RESET          12'h000
`define INPUT_RESET         12'h000
`define OFFSET_GAIN6_RESET  12'h99A
`define OFFSET_GAIN4_RESET  12'hAAB
`define TRIM_BIAS           13'h0800
`define CODE_MAX            12'hFFF

`endif

// [core/dac_cal_pkg.sv]
/*
 * Types shared by the channel calibration path.
 * Assumes the constants header is available on the include path.
 */
package dac_cal_pkg;
  typedef logic [11:0] code_t;
  typedef logic [2:0]  chan_t;

  typedef enum logic [1:0] {
    WR_IDLE = 2'b00,
    WR_RESP = 2'b01
  } wr_state_e;

  typedef struct packed {
    code_t [7:0] input_q;
    code_t [7:0] data_q;
    code_t [7:0] gain_q;
    code_t [7:0] zero_q;
    code_t [7:0] latch_q;
    code_t [1:0] offset_q;
    logic        ce_q;
    logic        gain4_q;
    logic        single_q;
    logic [7:0]  pend_q;
    logic        aw_held_q;
    logic        w_held_q;
    logic [11:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0]  wstrb_q;
    logic        bvalid_q;
    logic        rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0]  rresp_q;
    logic [1:0]  bresp_q;
  } state_s;
endpackage

// [core/dac_channel_calibration_path.sv]
/*
 * Digital data path of an eight-channel 12-bit converter: AXI4-Lite register slave, per-channel
 * gain and zero trim, one shared correction engine, data registers and converter latches.
 * Assumes a single 25 MHz clock, a synchronous active-high reset and a statically tied format pin.
 */
// The implementer's own choices: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps
`include "dac_cal_regs.svh"

// Notes on behaviour
// RULE1: Each channel's latch code alone drives that channel's conversion value output.
// RULE2: One configuration bit selects output amplification six or four.
// RULE3: Channels 0-3 with offset A form group A; 4-7 with offset B group B.
// RULE4: Every channel has gain and zero trim; one shared correction engine.
// RULE5: With correction on, input, gain or zero writes recompute into the data register.
// RULE6: Corrected code is input times (gain plus 2^11) over 2^12 plus signed zero.
// RULE7: Gain coefficient spans 0.5 to 1.5 with the trim code.
// RULE8: Zero trim spans -2048 to +2047 LSB.
// RULE9: Correction off passes written data unchanged; correction on applies it.
// RULE10: With correction off, trim writes only store and read back.
// RULE11: Raw code comes from input register when on, data register when off.
// RULE12: Data register holds results before transfer to the latch, double buffering.
// RULE13: Format pin low means straight binary, high means twos complement input and offset.
// RULE14: Bipolar straight binary: 800h zero, 000h minus, FFFh plus full scale.
// RULE15: Bipolar twos complement: 000h zero, 800h minus, 7FFh plus full scale.
// RULE16: Unipolar twos complement 800h is zero; straight binary 000h is zero.
// RULE17: Gain trim is always straight binary, zero trim always twos complement.
// RULE18: Reads return data in the format in which it was written.
// RULE19: Reset puts gain trim 2048, zero trim 0, inputs 000h.
// RULE20: Dual supply offset codes default near 2458 at gain six, 2731 at four.
// RULE21: Single supply holds both offset converters powered down.
// RULE22: A gain-select change reloads both offset codes with the new gain default.
// RULE23: Corrected code saturates to 0..4095 rather than wrapping.
// RULE24: Pending recomputations queue per channel and are served one at a time.
module dac_channel_calibration_path (
  input  wire logic                  clk_sys_i,
  input  wire logic                  reset_i,
  input  wire logic                  format_select_i,
  input  wire logic [11:0]           s_axi_awaddr_i,
  input  wire logic                  s_axi_awvalid_i,
  output logic                       s_axi_awready_o,
  input  wire logic [31:0]           s_axi_wdata_i,
  input  wire logic [3:0]            s_axi_wstrb_i,
  input  wire logic                  s_axi_wvalid_i,
  output logic                       s_axi_wready_o,
  output logic [1:0]                 s_axi_bresp_o,
  output logic                       s_axi_bvalid_o,
  input  wire logic                  s_axi_bready_i,
  input  wire logic [11:0]           s_axi_araddr_i,
  input  wire logic                  s_axi_arvalid_i,
  output logic                       s_axi_arready_o,
  output logic [31:0]                s_axi_rdata_o,
  output logic [1:0]                 s_axi_rresp_o,
  output logic                       s_axi_rvalid_o,
  input  wire logic                  s_axi_rready_i,
  output dac_cal_pkg::code_t [7:0]   channel_code_o,
  output logic                       gain_six_o,
  output dac_cal_pkg::code_t [1:0]   group_offset_code_o,
  output logic [1:0]                 offset_powered_down_o,
  output logic                       twos_complement_format_o,
  output logic                       engine_busy_o
);
  import dac_cal_pkg::*;

  state_s s_q;
  state_s s_d;

  // Applies trim to one raw code and clamps the result into the 12-bit range.
  function automatic code_t correct(input code_t raw, input code_t gain, input code_t zero);
    logic [24:0] prod;
    logic signed [14:0] sum;
    prod = 25'(raw) * 25'({1'b0, gain} + `TRIM_BIAS); // RULE6 RULE7 RULE17
    sum  = $signed({2'b00, prod[24:12]}) + 15'($signed(zero)); // RULE6 RULE8 RULE17
    if (sum < 15'sd0) begin
      correct = 12'h000; // RULE23
    end else if (sum > $signed({3'b000, `CODE_MAX})) begin
      correct = `CODE_MAX; // RULE23
    end else begin
      correct = sum[11:0];
    end
  endfunction

  // Returns the lowest pending channel so the engine serves one request at a time.
  function automatic chan_t pick(input logic [7:0] pend);
    pick = 3'd0;
    for (int i = 7; i >= 0; i--) begin
      if (pend[i]) begin
        pick = chan_t'(i);
      end
    end
  endfunction

  // Returns the register word at a byte address, or zero with an error flag when unmapped.
  function automatic logic [32:0] read_word(input state_s s, input logic [11:0] a);
    chan_t ch;
    ch = a[4:2];
    read_word = 33'h0_0000_0000;
    if (a == `CFG_OFFSET) begin
      read_word[`CFG_CE_BIT]     = s.ce_q;
      read_word[`CFG_GAIN_BIT]   = s.gain4_q;
      read_word[`CFG_SINGLE_BIT] = s.single_q;
    end else if (a == `STATUS_OFFSET) begin
      read_word[7:0] = s.pend_q;
      read_word[8]   = format_select_i;
    end else if (a == `OFFSET_A_OFFSET) begin
      read_word[11:0] = s.offset_q[0];
    end else if (a == `OFFSET_B_OFFSET) begin
      read_word[11:0] = s.offset_q[1];
    end else if (a[11:5] == `INPUT_BASE >> 5) begin
      read_word[11:0] = s.input_q[ch]; // RULE18
    end else if (a[11:5] == `DATA_BASE >> 5) begin
      read_word[11:0] = s.data_q[ch];
    end else if (a[11:5] == `GAIN_BASE >> 5) begin
      read_word[11:0] = s.gain_q[ch]; // RULE10 RULE18
    end else if (a[11:5] == `ZERO_BASE >> 5) begin
      read_word[11:0] = s.zero_q[ch]; // RULE10 RULE18
    end else if (a[11:5] == `LATCH_BASE >> 5) begin
      read_word[11:0] = s.latch_q[ch];
    end else begin
      read_word[32] = 1'b1;
    end
  endfunction

  logic  do_write;
  chan_t eng_ch;
  logic [32:0] rd_word;

  assign do_write = s_q.aw_held_q && s_q.w_held_q && !s_q.bvalid_q;
  assign eng_ch   = pick(s_q.pend_q);
  assign rd_word  = read_word(s_q, s_axi_araddr_i);

  always_comb begin
    chan_t       ch;
    logic [11:0] a;
    logic [11:0] wv;
    logic        hit;
    s_d = s_q;
    a   = s_q.awaddr_q;
    ch  = a[4:2];
    wv  = s_q.wdata_q[11:0];
    hit = 1'b1;

    // The shared engine retires one channel per cycle into its data register.
    if (s_q.ce_q && (s_q.pend_q != 8'h00)) begin
      s_d.data_q[eng_ch] = correct(s_q.input_q[eng_ch], s_q.gain_q[eng_ch], s_q.zero_q[eng_ch]); // RULE4 RULE5 RULE11
      s_d.pend_q[eng_ch] = 1'b0; // RULE24
    end

    if (!s_q.aw_held_q && s_axi_awvalid_i) begin
      s_d.aw_held_q = 1'b1;
      s_d.awaddr_q  = s_axi_awaddr_i;
    end
    if (!s_q.w_held_q && s_axi_wvalid_i) begin
      s_d.w_held_q = 1'b1;
      s_d.wdata_q  = s_axi_wdata_i;
      s_d.wstrb_q  = s_axi_wstrb_i;
    end

    if (do_write) begin
      s_d.aw_held_q = 1'b0;
      s_d.w_held_q  = 1'b0;
      s_d.bvalid_q  = 1'b1;
      if (a == `CFG_OFFSET) begin
        if (s_q.wstrb_q[0]) begin
          s_d.ce_q     = s_q.wdata_q[`CFG_CE_BIT]; // RULE9
          s_d.gain4_q  = s_q.wdata_q[`CFG_GAIN_BIT]; // RULE2
          s_d.single_q = s_q.wdata_q[`CFG_SINGLE_BIT];
          if (s_q.wdata_q[`CFG_GAIN_BIT] != s_q.gain4_q) begin
            s_d.offset_q[0] = s_q.wdata_q[`CFG_GAIN_BIT] ? `OFFSET_GAIN4_RESET : `OFFSET_GAIN6_RESET; // RULE22
            s_d.offset_q[1] = s_q.wdata_q[`CFG_GAIN_BIT] ? `OFFSET_GAIN4_RESET : `OFFSET_GAIN6_RESET; // RULE22
          end
          if (s_q.wdata_q[`CFG_LOAD_BIT]) begin
            s_d.latch_q = s_q.data_q; // RULE12
          end
        end
      end else if (a == `OFFSET_A_OFFSET || a == `OFFSET_B_OFFSET) begin
        if (s_q.wstrb_q[1:0] == 2'b11) begin
          s_d.offset_q[a[2]] = wv; // RULE3 RULE13
        end
      end else if (a[11:5] == `INPUT_BASE >> 5) begin
        if (s_q.wstrb_q[1:0] == 2'b11) begin
          s_d.input_q[ch] = wv; // RULE11 RULE13
          s_d.pend_q[ch]  = s_q.ce_q; // RULE5 RULE24
        end
      end else if (a[11:5] == `DATA_BASE >> 5) begin
        if (s_q.wstrb_q[1:0] == 2'b11) begin
          s_d.data_q[ch] = wv; // RULE9 RULE11 RULE14 RULE15 RULE16
        end
      end else if (a[11:5] == `GAIN_BASE >> 5) begin
        if (s_q.wstrb_q[1:0] == 2'b11) begin
          s_d.gain_q[ch] = wv; // RULE10 RULE17
          s_d.pend_q[ch] = s_q.ce_q; // RULE5 RULE10
        end
      end else if (a[11:5] == `ZERO_BASE >> 5) begin
        if (s_q.wstrb_q[1:0] == 2'b11) begin
          s_d.zero_q[ch] = wv; // RULE10 RULE17
          s_d.pend_q[ch] = s_q.ce_q; // RULE5 RULE10
        end
      end else if (a == `STATUS_OFFSET || a[11:5] == `LATCH_BASE >> 5) begin
        hit = 1'b1;
      end else begin
        hit = 1'b0;
      end
      s_d.bresp_q = hit ? 2'b00 : 2'b10;
    end
    if (s_q.bvalid_q && s_axi_bready_i) begin
      s_d.bvalid_q = 1'b0;
    end

    if (!s_q.rvalid_q && s_axi_arvalid_i) begin
      s_d.rvalid_q = 1'b1;
      s_d.rdata_q  = rd_word[31:0];
      s_d.rresp_q  = rd_word[32] ? 2'b10 : 2'b00;
    end else if (s_q.rvalid_q && s_axi_rready_i) begin
      s_d.rvalid_q = 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      s_q          <= '0;
      s_q.input_q  <= {8{`INPUT_RESET}}; // RULE19
      s_q.gain_q   <= {8{`GAIN_RESET}}; // RULE19
      s_q.zero_q   <= {8{`ZERO_RESET}}; // RULE19
      s_q.offset_q <= {2{`OFFSET_GAIN6_RESET}}; // RULE20
    end else begin
      s_q <= s_d;
    end
  end

  assign s_axi_awready_o          = !s_q.aw_held_q;
  assign s_axi_wready_o           = !s_q.w_held_q;
  assign s_axi_bvalid_o           = s_q.bvalid_q;
  assign s_axi_bresp_o            = s_q.bresp_q;
  assign s_axi_arready_o          = !s_q.rvalid_q;
  assign s_axi_rvalid_o           = s_q.rvalid_q;
  assign s_axi_rdata_o            = s_q.rdata_q;
  assign s_axi_rresp_o            = s_q.rresp_q;
  assign channel_code_o           = s_q.latch_q; // RULE1
  assign gain_six_o               = !s_q.gain4_q; // RULE2
  assign group_offset_code_o      = s_q.offset_q; // RULE3
  assign offset_powered_down_o    = {2{s_q.single_q}}; // RULE21
  assign twos_complement_format_o = format_select_i; // RULE13
  assign engine_busy_o            = s_q.ce_q && (s_q.pend_q != 8'h00);
endmodule

// [tb/dac_cal_chk.sv]
/* Port assertions for the channel calibration path.
   Assumes binding to dac_channel_calibration_path on its one clock. */
`timescale 1ns/1ps
`include "dac_cal_regs.svh"
module dac_cal_chk (
  input wire logic                     clk_sys_i,
  input wire logic                     reset_i,
  input wire logic                     format_select_i,
  input wire logic                     s_axi_awvalid_i,
  input wire logic                     s_axi_awready_o,
  input wire logic                     s_axi_wvalid_i,
  input wire logic                     s_axi_wready_o,
  input wire logic [1:0]               s_axi_bresp_o,
  input wire logic                     s_axi_bvalid_o,
  input wire logic                     s_axi_bready_i,
  input wire logic                     s_axi_arready_o,
  input wire logic                     s_axi_rvalid_o,
  input wire logic                     s_axi_rready_i,
  input wire logic                     gain_six_o,
  input wire dac_cal_pkg::code_t [1:0] group_offset_code_o,
  input wire logic [1:0]               offset_powered_down_o,
  input wire logic                     twos_complement_format_o,
  input wire logic                     engine_busy_o
);
  import dac_cal_pkg::*;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);
  AST_FMT: assert property (twos_complement_format_o == format_select_i)
    else $error("format flag differs from pin");
  AST_WR: assert property (s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o
    |-> ##[1:2] s_axi_bvalid_o) else $error("write response missing");
  AST_BDONE: assert property (s_axi_bvalid_o && s_axi_bready_i |=> !s_axi_bvalid_o) else $error("bvalid stuck");
  AST_RDONE: assert property (s_axi_rvalid_o && s_axi_rready_i |=> !s_axi_rvalid_o) else $error("rvalid stuck");
  AST_AR: assert property (s_axi_arready_o == !s_axi_rvalid_o) else $error("arready wrong");
  AST_OFS: assert property ($changed(gain_six_o) |-> ##[0:1] group_offset_code_o ==
    (gain_six_o ? {2{`OFFSET_GAIN6_RESET}} : {2{`OFFSET_GAIN4_RESET}})) else $error("offset not reloaded");
  AST_PD: assert property (offset_powered_down_o[0] == offset_powered_down_o[1])
    else $error("offset power states differ");
  AST_BUSY: assert property (engine_busy_o |-> ##[1:16] !engine_busy_o)
    else $error("engine never idles");
  cover property (s_axi_bvalid_o && s_axi_bresp_o == 2'b10);
  cover property ($rose(engine_busy_o));
  cover property ($changed(gain_six_o));
endmodule
bind dac_channel_calibration_path dac_cal_chk dac_cal_chk_inst (.clk_sys_i, .reset_i, .format_select_i,
  .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o,
  .s_axi_bready_i, .s_axi_arready_o, .s_axi_rvalid_o, .s_axi_rready_i, .gain_six_o, .group_offset_code_o,
  .offset_powered_down_o, .twos_complement_format_o, .engine_busy_o);

// [tb/axi_host.sv]
/* Host model: an AXI4-Lite master that programs the calibration path.
   Assumes tasks are entered just after a rising edge of the shared clock. */
`timescale 1ns/1ps
module axi_host (
  input  wire logic        clk_sys_i,
  output logic      [11:0] awaddr_o,
  output logic             awvalid_o,
  input  wire logic        awready_i,
  output logic      [31:0] wdata_o,
  output logic      [3:0]  wstrb_o,
  output logic             wvalid_o,
  input  wire logic        wready_i,
  input  wire logic [1:0]  bresp_i,
  input  wire logic        bvalid_i,
  output logic             bready_o,
  output logic      [11:0] araddr_o,
  output logic             arvalid_o,
  input  wire logic        arready_i,
  input  wire logic [31:0] rdata_i,
  input  wire logic [1:0]  rresp_i,
  input  wire logic        rvalid_i,
  output logic             rready_o
);
  initial begin
    {awaddr_o, awvalid_o, wdata_o, wstrb_o, wvalid_o, bready_o, araddr_o, arvalid_o, rready_o} = '0;
  end
  task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ap;
    logic wp;
    {ap, wp} = 2'b11;
    {awaddr_o, wdata_o, wstrb_o, awvalid_o, wvalid_o, bready_o} <= {a, d, 4'hF, 3'b111};
    while (ap || wp) begin
      @(posedge clk_sys_i);
      ap = ap && !awready_i;
      wp = wp && !wready_i;
      {awvalid_o, wvalid_o} <= {ap, wp};
    end
    do @(posedge clk_sys_i); while (!bvalid_i);
    r = bresp_i;
    bready_o <= 1'b0;
    @(posedge clk_sys_i);
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    {araddr_o, arvalid_o, rready_o} <= {a, 2'b11};
    do @(posedge clk_sys_i); while (!arready_i);
    arvalid_o <= 1'b0;
    do @(posedge clk_sys_i); while (!rvalid_i);
    {d, r} = {rdata_i, rresp_i};
    rready_o <= 1'b0;
    @(posedge clk_sys_i);
  endtask
endmodule

// [tb/tb.sv]
/* Self-checking bench for the channel calibration path.
   Assumes the host model and the checker are compiled before it. */
`timescale 1ns/1ps
`include "dac_cal_regs.svh"
module tb;
  import dac_cal_pkg::*;
  logic        clk_sys_i, reset_i, format_select_i, gain_six_o, twos_complement_format_o, engine_busy_o;
  logic [11:0] s_axi_awaddr_i, s_axi_araddr_i;
  logic [31:0] s_axi_wdata_i, s_axi_rdata_o;
  logic [3:0]  s_axi_wstrb_i;
  logic [1:0]  s_axi_bresp_o, s_axi_rresp_o, offset_powered_down_o;
  logic        s_axi_awvalid_i, s_axi_awready_o, s_axi_wvalid_i, s_axi_wready_o, s_axi_bvalid_o, s_axi_bready_i;
  logic        s_axi_arvalid_i, s_axi_arready_o, s_axi_rvalid_o, s_axi_rready_i;
  code_t [7:0] channel_code_o;
  code_t [1:0] group_offset_code_o;
  int          num_errors = 0;
  int          samples_checked = 0;
  // Rows: channel, input, gain trim, zero trim, expected corrected code.
  localparam logic [50:0] ROWS [6] = '{{3'd0, 12'h800, 12'h800, 12'h000, 12'h800},
    {3'd3, 12'hFFF, 12'hFFF, 12'h000, 12'hFFF}, {3'd4, 12'h800, 12'h000, 12'h000, 12'h400},
    {3'd7, 12'h100, 12'h800, 12'h800, 12'h000}, {3'd5, 12'h400, 12'h800, 12'h7FF, 12'hBFF},
    {3'd1, 12'h123, 12'h400, 12'hFFF, 12'h0D9}};
  dac_channel_calibration_path dac_channel_calibration_path_inst (.clk_sys_i, .reset_i, .format_select_i,
    .s_axi_awaddr_i, .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wdata_i, .s_axi_wstrb_i, .s_axi_wvalid_i,
    .s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_araddr_i, .s_axi_arvalid_i,
    .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rresp_o, .s_axi_rvalid_o, .s_axi_rready_i, .channel_code_o,
    .gain_six_o, .group_offset_code_o, .offset_powered_down_o, .twos_complement_format_o, .engine_busy_o);
  axi_host axi_host_inst (.clk_sys_i, .awaddr_o(s_axi_awaddr_i), .awvalid_o(s_axi_awvalid_i),
    .awready_i(s_axi_awready_o), .wdata_o(s_axi_wdata_i), .wstrb_o(s_axi_wstrb_i), .wvalid_o(s_axi_wvalid_i),
    .wready_i(s_axi_wready_o), .bresp_i(s_axi_bresp_o), .bvalid_i(s_axi_bvalid_o), .bready_o(s_axi_bready_i),
    .araddr_o(s_axi_araddr_i), .arvalid_o(s_axi_arvalid_i), .arready_i(s_axi_arready_o),
    .rdata_i(s_axi_rdata_o), .rresp_i(s_axi_rresp_o), .rvalid_i(s_axi_rvalid_o), .rready_o(s_axi_rready_i));
  initial begin
    clk_sys_i = 1'b0;
    forever #20 clk_sys_i = ~clk_sys_i;
  end
  task automatic chk_code(input code_t got, input code_t exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected code at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected response at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic put(input logic [11:0] a, input code_t d, input logic [1:0] e);
    logic [1:0] r;
    axi_host_inst.wr(a, {20'h0_0000, d}, r);
    chk_resp(r, e);
  endtask
  task automatic get(input logic [11:0] a, input code_t e, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0]  r;
    axi_host_inst.rd(a, d, r);
    chk_resp(r, er);
    chk_code(d[11:0], e);
  endtask
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // Whole sequence needs well under a thousand cycles.
  initial begin
    #400000;
    num_errors++;
    final_report();
  end
  initial begin
    logic [50:0] w;
    logic [11:0] o;
    {reset_i, format_select_i} = 2'b10;
    repeat (3) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    chk_code(group_offset_code_o[0], `OFFSET_GAIN6_RESET);
    chk_code({11'h0, gain_six_o}, 12'h001);
    get(`GAIN_BASE + 12'h018, `GAIN_RESET, 2'b00);
    get(`ZERO_BASE + 12'h018, `ZERO_RESET, 2'b00);
    get(`INPUT_BASE + 12'h018, `INPUT_RESET, 2'b00);
    put(`CFG_OFFSET, 12'h001, 2'b00);
    foreach (ROWS[i]) begin
      w = ROWS[i];
      o = {7'h00, w[50:48], 2'b00};
      put(`GAIN_BASE + o, w[35:24], 2'b00);
      put(`ZERO_BASE + o, w[23:12], 2'b00);
      put(`INPUT_BASE + o, w[47:36], 2'b00);
      for (int k = 0; k < 20 && engine_busy_o !== 1'b0; k++) @(posedge clk_sys_i);
      get(`DATA_BASE + o, w[11:0], 2'b00);
    end
    chk_code(channel_code_o[0], 12'h000);
    put(`CFG_OFFSET, 12'h009, 2'b00);
    foreach (ROWS[i]) chk_code(channel_code_o[ROWS[i][50:48]], ROWS[i][11:0]);
    put(`CFG_OFFSET, 12'h000, 2'b00);
    put(`GAIN_BASE + 12'h008, 12'h123, 2'b00);
    get(`GAIN_BASE + 12'h008, 12'h123, 2'b00);
    get(`DATA_BASE + 12'h008, 12'h000, 2'b00);
    put(`DATA_BASE + 12'h008, 12'h456, 2'b00);
    get(`DATA_BASE + 12'h008, 12'h456, 2'b00);
    put(`CFG_OFFSET, 12'h006, 2'b00);
    chk_code(group_offset_code_o[1], `OFFSET_GAIN4_RESET);
    chk_code({10'h000, offset_powered_down_o}, 12'h003);
    chk_code({11'h0, gain_six_o}, 12'h000);
    put(12'h100, 12'h001, 2'b10);
    get(12'h100, 12'h000, 2'b10);
    format_select_i <= 1'b1;
    get(`STATUS_OFFSET, 12'h100, 2'b00);
    // A second reset in mid-run must restore the power-on defaults.
    reset_i <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    @(posedge clk_sys_i);
    chk_code(group_offset_code_o[1], `OFFSET_GAIN6_RESET);
    chk_code({11'h0, gain_six_o}, 12'h001);
    get(`GAIN_BASE + 12'h008, `GAIN_RESET, 2'b00);
    final_report();
  end
endmodule
